// ===== src/sbfu_consts.vh
// Constants for the shifter bit-field unit: register offsets, field
// positions, opcodes and reset values.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
`ifndef SBFU_CONSTS_VH
`define SBFU_CONSTS_VH

// ==========================================================
// Register byte offsets
`define SBFU_OFF_CTRL      8'h00
`define SBFU_OFF_SRC       8'h04
`define SBFU_OFF_CTLOP     8'h08
`define SBFU_OFF_IMM       8'h0C
`define SBFU_OFF_DEST      8'h10
`define SBFU_OFF_DEXT      8'h14
`define SBFU_OFF_CMD       8'h18
`define SBFU_OFF_STATUS    8'h1C

// ==========================================================
// Field positions
`define SBFU_CTRL_OP_HI    7
`define SBFU_CTRL_OP_LO    0
`define SBFU_CTRL_IMMSEL   8
`define SBFU_CTLOP_POS_HI  5
`define SBFU_CTLOP_POS_LO  0
`define SBFU_CTLOP_LEN_HI  11
`define SBFU_CTLOP_LEN_LO  6
`define SBFU_IMM_D8_HI     7
`define SBFU_IMM_D8_LO     0
`define SBFU_IMM_POS_HI    21
`define SBFU_IMM_POS_LO    16
`define SBFU_IMM_LEN_HI    29
`define SBFU_IMM_LEN_LO    24
`define SBFU_CMD_GO        0
`define SBFU_ST_ZERO       0
`define SBFU_ST_OVF        1
`define SBFU_ST_SIGN       2
`define SBFU_ST_ERR        3
`define SBFU_OP_SE_BIT     3
`define SBFU_OP_OR_BIT     5

// ==========================================================
// Opcodes
`define SBFU_OP_BIT_SET    8'hC0
`define SBFU_OP_BIT_TGL    8'hC8
`define SBFU_OP_BIT_TST    8'hCC
`define SBFU_OP_DEP        8'h44
`define SBFU_OP_DEP_OR     8'h64
`define SBFU_OP_DEP_SE     8'h4C
`define SBFU_OP_DEP_SE_OR  8'h6C
`define SBFU_OP_EXT        8'h40

// ==========================================================
// Widths and reset values
`define SBFU_FIX_W         32
`define SBFU_EXT_W         8
`define SBFU_MAX_BIT       31
`define SBFU_RST_WORD      32'h00000000
`define SBFU_RST_CTRL      9'h000
`define SBFU_RST_EXT       8'h00

`endif

// ===== src/sbfu_field_unit.v
// Combinational field deposit and extract datapath.
// Assumes start and length are 0..63 and operands are 32-bit fixed fields.
`timescale 1ns/1ns
`default_nettype none

module sbfu_field_unit #(
	parameter W = 32
) (
	input  wire [W-1:0] src_i,
	input  wire [W-1:0] old_i,
	input  wire [5:0]   start_i,
	input  wire [5:0]   len_i,
	input  wire         sext_i,
	input  wire         merge_i,
	input  wire         extract_i,
	output wire [W-1:0] result_o,
	output wire         ovf_o
);

	// ==========================================================
	// Length mask, one bit per position
	wire [W-1:0]   len_mask;
	wire [6:0]     end_pos;
	genvar         gi;

	generate
		for (gi = 0; gi < W; gi = gi + 1) begin : g_mask
			localparam [6:0] bit_idx = gi;
			assign len_mask[gi] = ({1'b0, len_i} > bit_idx);
		end
	endgenerate

	assign end_pos = {1'b0, start_i} + {1'b0, len_i};

	// ==========================================================
	// Deposit: sign-extend in double width, then position
	reg  [2*W-1:0] field_wide;
	reg  [2*W-1:0] placed_wide;
	reg  [W-1:0]   dep_val;
	reg  [W-1:0]   ext_val;
	reg  [W-1:0]   top_bit;
	reg            sign_bit;

	always @* begin
		top_bit = len_mask & ~(len_mask >> 1);
		sign_bit = sext_i & (|(src_i & top_bit));
		field_wide = {{W{sign_bit}}, (src_i & len_mask) | ({W{sign_bit}} & ~len_mask)};
		if (len_i == 6'h00) begin
			field_wide = {(2*W){1'b0}};
		end
		placed_wide = field_wide << start_i; // RULE12 RULE17
		dep_val = placed_wide[W-1:0]; // RULE14
		if (merge_i) begin
			dep_val = dep_val | old_i; // RULE16 RULE18
		end
		ext_val = (src_i >> start_i) & len_mask; // RULE20 RULE21
	end

	assign result_o = extract_i ? ext_val : dep_val; // RULE11 RULE13
	assign ovf_o    = (end_pos > 7'd32); // RULE15

endmodule

`default_nettype wire

// ===== src/sbfu_shifter_unit.v
// Shifter bit-field unit with APB register access.
// Assumes an APB master on core_clk_i; operands are fixed-point fields.
//
// Contract
// (RULE1) Operate on bits 39:8 fixed-point field
// (RULE2) Bit-set forces selected source bit to one
// (RULE3) Bit-toggle inverts selected bit, others copied
// (RULE4) Extension byte cleared on every write
// (RULE5) Position out of 0..31 leaves operand
// (RULE6) Bit-test zero flag reflects selected bit
// (RULE7) Bit-test zero flag set above 31
// (RULE8) Overflow only above 31; sign cleared
// (RULE9) Zero flag from written 32-bit result
// (RULE10) Decode C0, C8, CC single-bit ops
// (RULE11) Deposit field right-aligned, length selectable
// (RULE12) Field LSB placed at start position
// (RULE13) Plain deposit zeroes outside bits, extension
// (RULE14) Start, length 0..63; overflow bits dropped
// (RULE15) Deposit overflow when start plus length>32
// (RULE16) OR-merge deposit into existing destination
// (RULE17) Sign-extend above field unless off-scale
// (RULE18) Sign-extended value ORed into destination
// (RULE19) Decode 44, 64, 4C, 6C deposits
// (RULE20) Extract field right-aligned into destination
// (RULE21) Extract zeroes upper bits and extension
// (RULE22) Start, length from two 6-bit fields
// (RULE23) Result and flags together, one cycle
`include "sbfu_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module sbfu_shifter_unit (
	input  wire        core_clk_i,
	input  wire        rst_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	input  wire [3:0]  pstrb_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	output wire [39:0] destination_reg_o,
	output wire        shifter_zero_flag_o,
	output wire        shifter_overflow_flag_o,
	output wire        shifter_sign_flag_o,
	output wire        result_valid_o
);

	// ==========================================================
	// State
	reg  [8:0]  ctrl_q;
	reg  [31:0] src_fix_q;
	reg  [31:0] control_operand_reg_q;
	reg  [31:0] imm_q;
	reg  [31:0] dest_fix_q;
	reg  [7:0]  dest_ext_q;
	reg         zero_q;
	reg         ovf_q;
	reg         sign_q;
	reg         err_q;
	reg         valid_q;
	reg         pready_q;
	reg         pslverr_q;
	reg  [31:0] prdata_q;

	// ==========================================================
	// Byte-lane merge for APB writes
	function [31:0] lane_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer      k;
		begin
			lane_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================================
	// APB decode
	wire        acc_phase;
	wire        commit;
	wire        wr_commit;
	reg         addr_hit;
	reg  [31:0] rd_val;

	assign acc_phase = psel_i & penable_i;
	assign commit    = acc_phase & pready_q;
	assign wr_commit = commit & pwrite_i & addr_hit;

	always @* begin
		addr_hit = 1'b1;
		rd_val   = `SBFU_RST_WORD;
		case (paddr_i)
			`SBFU_OFF_CTRL:   rd_val = {23'h000000, ctrl_q};
			`SBFU_OFF_SRC:    rd_val = src_fix_q;
			`SBFU_OFF_CTLOP:  rd_val = control_operand_reg_q;
			`SBFU_OFF_IMM:    rd_val = imm_q;
			`SBFU_OFF_DEST:   rd_val = dest_fix_q;
			`SBFU_OFF_DEXT:   rd_val = {24'h000000, dest_ext_q};
			`SBFU_OFF_CMD:    rd_val = `SBFU_RST_WORD;
			`SBFU_OFF_STATUS: rd_val = {28'h0000000, err_q, sign_q, ovf_q, zero_q};
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `SBFU_RST_WORD;
		end else begin
			pready_q  <= acc_phase & ~pready_q;
			pslverr_q <= acc_phase & ~pready_q & ~addr_hit;
			if (acc_phase & ~pready_q & ~pwrite_i) begin
				prdata_q <= rd_val;
			end else if (pready_q) begin
				prdata_q <= `SBFU_RST_WORD;
			end
		end
	end

	// ==========================================================
	// Operand selection
	wire [7:0]  opcode;
	wire        imm_sel;
	wire [31:0] bit_pos;
	wire [5:0]  fld_start;
	wire [5:0]  fld_len;

	assign opcode  = ctrl_q[`SBFU_CTRL_OP_HI:`SBFU_CTRL_OP_LO];
	assign imm_sel = ctrl_q[`SBFU_CTRL_IMMSEL];
	assign bit_pos = imm_sel ?
		{{24{imm_q[`SBFU_IMM_D8_HI]}}, imm_q[`SBFU_IMM_D8_HI:`SBFU_IMM_D8_LO]} :
		control_operand_reg_q; // RULE2
	assign fld_start = imm_sel ? imm_q[`SBFU_IMM_POS_HI:`SBFU_IMM_POS_LO] :
		control_operand_reg_q[`SBFU_CTLOP_POS_HI:`SBFU_CTLOP_POS_LO]; // RULE22
	assign fld_len = imm_sel ? imm_q[`SBFU_IMM_LEN_HI:`SBFU_IMM_LEN_LO] :
		control_operand_reg_q[`SBFU_CTLOP_LEN_HI:`SBFU_CTLOP_LEN_LO]; // RULE22

	// ==========================================================
	// Single-bit datapath
	wire        pos_neg;
	wire        pos_big;
	wire        pos_ok;
	wire [31:0] bit_onehot;
	wire [31:0] set_val;
	wire [31:0] tgl_val;
	wire        probe_bit;

	assign pos_neg    = bit_pos[31];
	assign pos_big    = ~pos_neg & (|bit_pos[30:5]);
	assign pos_ok     = ~pos_neg & ~pos_big;
	assign bit_onehot = pos_ok ? (32'h00000001 << bit_pos[4:0]) : `SBFU_RST_WORD; // RULE5
	assign set_val    = src_fix_q | bit_onehot; // RULE2
	assign tgl_val    = src_fix_q ^ bit_onehot; // RULE3
	assign probe_bit  = |(src_fix_q & bit_onehot);

	// ==========================================================
	// Field datapath
	wire [31:0] fld_val;
	wire        fld_ovf;
	wire        is_extract;

	assign is_extract = (opcode == `SBFU_OP_EXT);

	sbfu_field_unit #(
		.W (`SBFU_FIX_W)
	) u_field (
		.src_i     (src_fix_q),
		.old_i     (dest_fix_q),
		.start_i   (fld_start),
		.len_i     (fld_len),
		.sext_i    (opcode[`SBFU_OP_SE_BIT] & ~is_extract),
		.merge_i   (opcode[`SBFU_OP_OR_BIT]),
		.extract_i (is_extract),
		.result_o  (fld_val),
		.ovf_o     (fld_ovf)
	);

	// ==========================================================
	// Operation decode
	reg  [31:0] res_d;
	reg         wr_dest_d;
	reg         zero_d;
	reg         ovf_d;
	reg         known_d;

	always @* begin
		res_d     = dest_fix_q;
		wr_dest_d = 1'b0;
		zero_d    = zero_q;
		ovf_d     = ovf_q;
		known_d   = 1'b1;
		case (opcode) // RULE10 RULE19
			`SBFU_OP_BIT_SET: begin
				res_d     = set_val;
				wr_dest_d = 1'b1;
				zero_d    = (set_val == `SBFU_RST_WORD); // RULE9
				ovf_d     = pos_big; // RULE8
			end
			`SBFU_OP_BIT_TGL: begin
				res_d     = tgl_val;
				wr_dest_d = 1'b1;
				zero_d    = (tgl_val == `SBFU_RST_WORD); // RULE9
				ovf_d     = pos_big; // RULE8
			end
			`SBFU_OP_BIT_TST: begin
				zero_d = ~pos_ok | ~probe_bit; // RULE6 RULE7
				ovf_d  = pos_big; // RULE8
			end
			`SBFU_OP_DEP,
			`SBFU_OP_DEP_OR,
			`SBFU_OP_DEP_SE,
			`SBFU_OP_DEP_SE_OR,
			`SBFU_OP_EXT: begin
				res_d     = fld_val; // RULE11 RULE20
				wr_dest_d = 1'b1;
				zero_d    = (fld_val == `SBFU_RST_WORD); // RULE9
				ovf_d     = fld_ovf; // RULE15
			end
			default: begin
				known_d = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Register writes and execution
	wire        exec;
	wire [31:0] ctrl_merged;

	assign exec = wr_commit & (paddr_i == `SBFU_OFF_CMD) & pstrb_i[0] &
		pwdata_i[`SBFU_CMD_GO];
	assign ctrl_merged = lane_merge({23'h000000, ctrl_q}, pwdata_i, pstrb_i);

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q                <= `SBFU_RST_CTRL;
			src_fix_q             <= `SBFU_RST_WORD;
			control_operand_reg_q <= `SBFU_RST_WORD;
			imm_q                 <= `SBFU_RST_WORD;
			dest_fix_q            <= `SBFU_RST_WORD;
			dest_ext_q            <= `SBFU_RST_EXT;
			zero_q                <= 1'b0;
			ovf_q                 <= 1'b0;
			sign_q                <= 1'b0;
			err_q                 <= 1'b0;
			valid_q               <= 1'b0;
		end else begin
			valid_q <= 1'b0;
			if (wr_commit) begin
				case (paddr_i)
					`SBFU_OFF_CTRL: begin
						ctrl_q <= ctrl_merged[8:0];
					end
					`SBFU_OFF_SRC: begin
						src_fix_q <= lane_merge(src_fix_q, pwdata_i, pstrb_i);
					end
					`SBFU_OFF_CTLOP: begin
						control_operand_reg_q <= lane_merge(control_operand_reg_q,
							pwdata_i, pstrb_i);
					end
					`SBFU_OFF_IMM: begin
						imm_q <= lane_merge(imm_q, pwdata_i, pstrb_i);
					end
					`SBFU_OFF_DEST: begin
						dest_fix_q <= lane_merge(dest_fix_q, pwdata_i, pstrb_i);
					end
					`SBFU_OFF_DEXT: begin
						if (pstrb_i[0]) begin
							dest_ext_q <= pwdata_i[7:0];
						end
					end
					default: begin
					end
				endcase
			end
			// Error is write-one-to-clear; a new error wins over the clear
			if (wr_commit & (paddr_i == `SBFU_OFF_STATUS) & pstrb_i[0] &
					pwdata_i[`SBFU_ST_ERR]) begin
				err_q <= 1'b0;
			end
			if (exec) begin
				if (known_d) begin
					valid_q <= 1'b1; // RULE23
					zero_q  <= zero_d;
					ovf_q   <= ovf_d;
					sign_q  <= 1'b0; // RULE8
					if (wr_dest_d) begin
						dest_fix_q <= res_d; // RULE1
						dest_ext_q <= `SBFU_RST_EXT; // RULE4 RULE13 RULE21
					end
				end else begin
					err_q <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Outputs
	assign prdata_o                = prdata_q;
	assign pready_o                = pready_q;
	assign pslverr_o               = pslverr_q;
	assign destination_reg_o       = {dest_fix_q, dest_ext_q}; // RULE1
	assign shifter_zero_flag_o     = zero_q;
	assign shifter_overflow_flag_o = ovf_q;
	assign shifter_sign_flag_o     = sign_q;
	assign result_valid_o          = valid_q;

endmodule

`default_nettype wire

// ===== verif/sbfu_apb_master.sv
// APB master model standing in for the core sequencer and register file.
// Assumes xfer is entered just after a rising edge of core_clk_i.
`timescale 1ns/1ns
`default_nettype none

module sbfu_apb_master (
	input  wire logic        core_clk_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	input  wire logic [31:0] prdata_i,
	output var  logic        psel_o    = 1'b0,
	output var  logic        penable_o = 1'b0,
	output var  logic        pwrite_o  = 1'b0,
	output var  logic [7:0]  paddr_o   = 8'h00,
	output var  logic [31:0] pwdata_o  = 32'h00000000,
	output var  logic [3:0]  pstrb_o   = 4'h0
);
	// ==========================================
	// One transfer, held until pready is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic to);
		int n;
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= 4'hF;
		@(posedge core_clk_i);
		penable_o <= 1'b1;
		to = 1'b1;
		for (n = 0; n < 16 && to; n++) begin
			@(posedge core_clk_i);
			to = !pready_i;
		end
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines show no stale value
		paddr_o <= ~a;
		pwdata_o <= ~d;
		// Idle edge so the next setup never re-raises psel in this step
		@(posedge core_clk_i);
	endtask
endmodule
`default_nettype wire

// ===== verif/sbfu_shifter_unit_asserts.sv
// Checker for the shifter bit-field unit, bound to its top module.
// Assumes full-word APB writes to load opcode and control operand.
`include "sbfu_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module sbfu_shifter_unit_asserts (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic        pready_o,
	input wire logic [39:0] destination_reg_o,
	input wire logic        shifter_zero_flag_o,
	input wire logic        shifter_overflow_flag_o,
	input wire logic        shifter_sign_flag_o,
	input wire logic        result_valid_o
);
	logic [7:0]  op_q;
	logic        imm_q;
	logic [31:0] ctl_q;
	logic        cmd_q;
	wire commit = psel_i & penable_i & pready_o & pwrite_i & (pstrb_i == 4'hF);
	wire tst = op_q == `SBFU_OP_BIT_TST;
	wire one = op_q == `SBFU_OP_BIT_SET || op_q == `SBFU_OP_BIT_TGL || tst;
	wire dep = op_q == `SBFU_OP_DEP || op_q == `SBFU_OP_DEP_OR
		|| op_q == `SBFU_OP_DEP_SE || op_q == `SBFU_OP_DEP_SE_OR;
	wire known = one || dep || op_q == `SBFU_OP_EXT;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_q <= 8'h00;
			imm_q <= 1'b0;
			ctl_q <= 32'h00000000;
			cmd_q <= 1'b0;
		end else begin
			cmd_q <= commit && paddr_i == `SBFU_OFF_CMD && pwdata_i[0];
			if (commit && paddr_i == `SBFU_OFF_CTRL) begin
				op_q <= pwdata_i[7:0];
				imm_q <= pwdata_i[8];
			end
			if (commit && paddr_i == `SBFU_OFF_CTLOP) begin
				ctl_q <= pwdata_i;
			end
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// ==========================================
	// Properties
	AST_SIGN_LOW: assert property (!shifter_sign_flag_o)
		else $error("sign flag set");
	AST_VALID_CAUSE: assert property (result_valid_o |-> cmd_q && known)
		else $error("result valid without a known command");
	AST_VALID_PULSE: assert property (cmd_q && known |-> result_valid_o ##1 !result_valid_o)
		else $error("result valid not a single pulse");
	AST_FLAG_HOLD: assert property ($changed({shifter_zero_flag_o, shifter_overflow_flag_o}) |-> cmd_q)
		else $error("flags changed without a command");
	AST_EXT_CLEAR: assert property (result_valid_o && !tst |-> destination_reg_o[7:0] == 8'h00)
		else $error("extension byte not cleared");
	AST_TEST_KEEP: assert property (result_valid_o && tst |-> $stable(destination_reg_o))
		else $error("bit test wrote destination");
	AST_BIT_OVF: assert property (result_valid_o && one && !imm_q
		|-> shifter_overflow_flag_o == ($signed(ctl_q) > 31))
		else $error("single bit overflow flag wrong");
	AST_TEST_HIGH: assert property (result_valid_o && tst && !imm_q && $signed(ctl_q) > 31
		|-> shifter_zero_flag_o)
		else $error("bit test zero flag clear above 31");
	AST_DEP_OVF: assert property (result_valid_o && dep && !imm_q |-> shifter_overflow_flag_o
		== (({1'b0, ctl_q[5:0]} + {1'b0, ctl_q[11:6]}) > 7'd32))
		else $error("deposit overflow flag wrong");
	AST_ZERO_RES: assert property (result_valid_o && !tst
		|-> shifter_zero_flag_o == (destination_reg_o[39:8] == 32'h00000000))
		else $error("zero flag does not match result");
endmodule

bind sbfu_shifter_unit sbfu_shifter_unit_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
	.destination_reg_o(destination_reg_o), .shifter_zero_flag_o(shifter_zero_flag_o),
	.shifter_overflow_flag_o(shifter_overflow_flag_o),
	.shifter_sign_flag_o(shifter_sign_flag_o), .result_valid_o(result_valid_o));
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the shifter bit-field unit.
// Assumes the APB master model and the bound checker.
`include "sbfu_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	wire         psel, penable, pwrite, pready, pslverr, zf, vf, sf, rv;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata, prdata;
	wire  [3:0]  pstrb;
	wire  [39:0] dest;
	int          err_count  = 0;
	int          compares   = 0;
	always #20 core_clk_i = ~core_clk_i;

	sbfu_apb_master m (.core_clk_i(core_clk_i), .pready_i(pready), .pslverr_i(pslverr),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
	sbfu_shifter_unit dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.destination_reg_o(dest), .shifter_zero_flag_o(zf), .shifter_overflow_flag_o(vf),
		.shifter_sign_flag_o(sf), .result_valid_o(rv));

	// ==========================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		logic to;
		m.xfer(w, a, d, r, e, to);
		if (to) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		bus(1'b1, a, d, r, e);
	endtask
	// Expected {zero, overflow, result}
	function automatic logic [33:0] model(input logic [7:0] op, input logic imm,
		input logic [31:0] src, input logic [31:0] old, input logic [31:0] ctl);
		int p;
		int s;
		int l;
		logic [63:0] f;
		logic [31:0] r;
		logic v;
		p = imm ? int'($signed(ctl[7:0])) : int'($signed(ctl));
		s = imm ? ctl[21:16] : ctl[5:0];
		l = imm ? ctl[29:24] : ctl[11:6];
		r = src;
		v = p > 31;
		if (!op[7]) begin
			v = s + l > 32;
			if (l > 32)
				l = 32;
			f = (op == `SBFU_OP_EXT) ? {32'h0, src} >> s : {32'h0, src};
			f = f & ((64'h1 << l) - 1);
			if (op[3] && l > 0 && s + l <= 32 && src[l-1])
				f = f | ~((64'h1 << l) - 1);
			if (op != `SBFU_OP_EXT)
				f = f << s;
			r = f[31:0] | (op[5] ? old : 32'h0);
		end else if (p >= 0 && p <= 31) begin
			r[p] = (op == `SBFU_OP_BIT_SET) ? 1'b1 : ~r[p];
		end
		if (op == `SBFU_OP_BIT_TST)
			return {p < 0 || p > 31 || !src[p], v, old};
		return {r == 32'h0, v, r};
	endfunction
	task automatic run(input logic [7:0] op, input logic imm, input logic [31:0] src,
		input logic [31:0] ctl);
		logic [33:0] x;
		logic [31:0] r;
		logic e;
		x = model(op, imm, src, 32'h0F0F0F0F, ctl);
		wr(`SBFU_OFF_CTRL, {23'h0, imm, op});
		wr(`SBFU_OFF_SRC, src);
		wr(imm ? `SBFU_OFF_IMM : `SBFU_OFF_CTLOP, ctl);
		wr(`SBFU_OFF_DEST, 32'h0F0F0F0F);
		wr(`SBFU_OFF_DEXT, 32'h000000A5);
		wr(`SBFU_OFF_CMD, 32'h00000001);
		bus(1'b0, `SBFU_OFF_DEST, 32'h0, r, e);
		check(r, x[31:0]);
		check(dest[39:8], x[31:0]);
		bus(1'b0, `SBFU_OFF_STATUS, 32'h0, r, e);
		check(r, {30'h0, x[32], x[33]});
		bus(1'b0, `SBFU_OFF_DEXT, 32'h0, r, e);
		check(r, (op == `SBFU_OP_BIT_TST) ? 32'hA5 : 32'h0);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		bus(1'b0, `SBFU_OFF_STATUS, 32'h0, r, e);
		check(r, 32'h0);
	endtask
	task automatic t_single();
		logic [7:0]  ops[3] = '{`SBFU_OP_BIT_SET, `SBFU_OP_BIT_TGL, `SBFU_OP_BIT_TST};
		logic [31:0] pos[5] = '{32'd0, 32'd31, 32'd32, 32'hFFFFFFFF, 32'd5};
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 5; j++)
				run(ops[i], 1'b0, 32'h5A5A0F0F, pos[j]);
			run(ops[i], 1'b1, 32'h5A5A0F0F, 32'h000000FF);
			run(ops[i], 1'b1, 32'h5A5A0F0F, 32'h0000001F);
		end
		run(`SBFU_OP_BIT_TGL, 1'b0, 32'h00000020, 32'd5);
	endtask
	task automatic t_field();
		logic [7:0] ops[5] = '{`SBFU_OP_DEP, `SBFU_OP_DEP_OR, `SBFU_OP_DEP_SE,
			`SBFU_OP_DEP_SE_OR, `SBFU_OP_EXT};
		int st[6] = '{13, 0, 20, 63, 0, 18};
		int ln[6] = '{14, 32, 20, 63, 0, 14};
		for (int i = 0; i < 5; i++) begin
			for (int j = 0; j < 6; j++) begin
				run(ops[i], 1'b0, 32'hFFFFBABC, 32'(ln[j] * 64 + st[j]));
				run(ops[i], 1'b1, 32'h00002ABC, 32'((ln[j] << 24) | (st[j] << 16)));
			end
		end
	endtask
	task automatic t_refuse();
		logic [31:0] r;
		logic e;
		wr(`SBFU_OFF_CTRL, 32'h00000048);
		wr(`SBFU_OFF_CMD, 32'h00000001);
		bus(1'b0, `SBFU_OFF_STATUS, 32'h0, r, e);
		check(r & 32'h8, 32'h8);
		wr(`SBFU_OFF_STATUS, 32'h00000008);
		bus(1'b0, `SBFU_OFF_STATUS, 32'h0, r, e);
		check(r & 32'h8, 32'h0);
		bus(1'b0, 8'h20, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
		bus(1'b1, 8'h02, 32'h1, r, e);
		check({31'h0, e}, 32'h1);
	endtask

	initial begin
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		t_reset();
		t_single();
		t_field();
		t_refuse();
		end_sim();
	end
endmodule
`default_nettype wire
